// [src/pol_seq_consts.svh]
// Purpose: constants of the rail sequencing control
// Assumes: clk_sys at 200 MHz
// Notes: times in their own unit, counts derived
`ifndef POL_SEQ_CONSTS_SVH
`define POL_SEQ_CONSTS_SVH
`define CLK_KHZ 200000
`define MS_US 1000
`define CLK_MHZ 200
`define MS_CYCLES_DEF (`MS_US * `CLK_MHZ)
`define TON_DELAY_DEF 8'h0A
`define TON_RISE_DEF 8'h0A
`define TOFF_DELAY_DEF 8'h0A
`define TOFF_FALL_DEF 8'h0A
`define POLL_MS_DEF 8'h0A
`define FREQ_DEF 10'h1C2
`define FREQ_550 10'h226
`define FREQ_650 10'h28A
`define FREQ_750 10'h2EE
`define FREQ_900 10'h384
`define BAND1_TOP 10'h1F4
`define BAND2_TOP 10'h258
`define BAND3_TOP 10'h2BC
`define BAND4_TOP 10'h334
`define FULL_TURN 9'h168
`endif

// [src/pol_seq_pkg.sv]
// Purpose: types of the rail sequencing control
// Assumes: constants come from pol_seq_consts.svh
// Notes: state of the top is one packed struct
package pol_seq_pkg;
  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_TON_DLY, SEQ_RISE, SEQ_ON, SEQ_TOFF_DLY, SEQ_FALL
  } seq_e;
  typedef enum logic [1:0] {SYNC_INTERNAL, SYNC_INPUT, SYNC_OUTPUT} sync_e;
  typedef struct packed {
    logic [7:0] ton_delay;
    logic [7:0] ton_rise;
    logic [7:0] toff_delay;
    logic [7:0] toff_fall;
    logic soft_stop;
    logic [9:0] freq_req;
    sync_e sync_mode;
    logic [2:0] phase_sel;
    logic ocl_ovr_en;
    logic [7:0] ocl_ovr;
  } cfg_s;
  typedef struct packed {
    seq_e seq;
    logic [17:0] ms_div;
    logic [7:0] tcnt;
    cfg_s cfg;
    logic [9:0] freq_eff;
    logic [9:0] per;
    logic [9:0] sw_cnt;
    logic [9:0] phase_off;
    logic [8:0] phase_deg;
    logic sync_prev;
    logic sync_out;
    logic sync_oe;
    logic sw_pulse;
    logic ready;
    logic run;
    logic sr_on;
    logic ramp_up;
    logic ramp_dn;
    logic [7:0] ocl;
    logic [7:0] ocl_strap;
    logic init;
    logic stack_lock;
    logic leader;
    logic follower;
    logic [1:0] units_m1;
    logic [1:0] order;
    logic relay;
    logic poll;
    logic [7:0] poll_cnt;
  } st_s;
endpackage : pol_seq_pkg

// [src/pol_rail_seq_ctrl.sv]
// Purpose: sequencing, power-good, frequency, sync and phase control
// Assumes: all inputs synchronous to clk_sys; straps steady at reset
// Notes: loop, current sharing and bus protocol live elsewhere
`timescale 1ns/100ps
`include "pol_seq_consts.svh"
// Contract
// - command or stored setting overrides strapped overcurrent limit
// - power-good high only when regulated output is ready
// - power-good low whenever anything keeps the module stopped
// - switching frequency is 450 kHz after reset until changed
// - requests up to 1000 kHz accepted; only five effective values
// - 411-500 gives 450, 501-600 gives 550, 601-700 gives 650
// - 701-820 gives 750, 821-1000 gives 900
// - sync pin configurable as clock output or following input
// - default runs on internal clock, ignoring the sync pin
// - phase offset applies only when running from common sync
// - standalone phase selectable 0, 90, 120, 180, 240, 270 degrees
// - stacked unit holds fixed phase, configuration cannot change it
// - on enable wait turn-on delay, then ramp over rise time
// - soft-stop: wait turn-off delay, then ramp down over fall time
// - defaults are 10 ms turn-on delay and 10 ms rise
// - soft-stop off by default; disable stops regulation at once
// - soft-stop and all four times set by configuration write
// - rectifiers never sink from pre-bias at start, stop or fault
// - stack of at most four units sharing current equally
// - leader relays setting changes and polls followers periodically
// - stack phase is 360 over unit count times order position
module pol_rail_seq_ctrl #(
  parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // configuration writes
  input wire logic cfg_wr,
  input wire pol_seq_pkg::cfg_s cfg_in,
  // straps
  input wire logic [7:0] ocl_strap_in,
  input wire logic follower_strap,
  input wire logic [1:0] stack_units_m1,
  input wire logic [1:0] stack_order,
  // control and events
  input wire logic rail_enable,
  input wire logic fault,
  input wire logic sync_in,
  // status
  output logic rail_ready_out_o,
  output logic rail_ready_out_oe,
  output logic sync_out,
  output logic sync_oe,
  output logic sw_pulse,
  output logic regulating,
  output logic ramping_up,
  output logic ramping_down,
  output logic rectifier_enable,
  output logic [9:0] freq_eff,
  output logic [8:0] phase_deg,
  output logic [7:0] ocl_limit,
  output logic relay_req,
  output logic poll_req
);
  pol_seq_pkg::st_s st_ff;
  pol_seq_pkg::st_s nxt_st;
  logic tick;
  logic [18:0] prod;

  function automatic logic [9:0] band_freq(input logic [9:0] req);
    if (req <= `BAND1_TOP) band_freq = `FREQ_DEF;
    else if (req <= `BAND2_TOP) band_freq = `FREQ_550;
    else if (req <= `BAND3_TOP) band_freq = `FREQ_650;
    else if (req <= `BAND4_TOP) band_freq = `FREQ_750;
    else band_freq = `FREQ_900;
  endfunction : band_freq

  function automatic logic [9:0] period_of(input logic [9:0] f);
    period_of = 10'(`CLK_KHZ / int'(f));
  endfunction : period_of

  function automatic logic [8:0] sel_deg(input logic [2:0] s);
    case (s)
      3'h1: sel_deg = 9'h05A;
      3'h2: sel_deg = 9'h078;
      3'h3: sel_deg = 9'h0B4;
      3'h4: sel_deg = 9'h0F0;
      3'h5: sel_deg = 9'h10E;
      default: sel_deg = 9'h000;
    endcase
  endfunction : sel_deg

  assign tick = (st_ff.ms_div == 18'(MS_CYCLES - 1));
  assign prod = 19'(st_ff.per) * 19'(st_ff.phase_deg);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.relay = 1'b0;
    nxt_st.poll = 1'b0;
    nxt_st.sw_pulse = 1'b0;
    nxt_st.ms_div = tick ? 18'h00000 : st_ff.ms_div + 18'h00001;
    if (!st_ff.init)
    begin
      nxt_st.init = 1'b1;
      nxt_st.ocl_strap = ocl_strap_in;
      nxt_st.follower = follower_strap;
      nxt_st.units_m1 = stack_units_m1;
      nxt_st.order = follower_strap ? stack_order : 2'h0;
      nxt_st.stack_lock = follower_strap || (stack_units_m1 != 2'h0);
      nxt_st.leader = !follower_strap && (stack_units_m1 != 2'h0);
    end
    if (cfg_wr)
    begin
      nxt_st.cfg = cfg_in;
      nxt_st.freq_eff = band_freq(cfg_in.freq_req);
      nxt_st.relay = st_ff.leader;
    end
    nxt_st.per = period_of(st_ff.freq_eff);
    nxt_st.ocl = st_ff.cfg.ocl_ovr_en ? st_ff.cfg.ocl_ovr : st_ff.ocl_strap;
    // phase position
    if (st_ff.stack_lock)
      nxt_st.phase_deg = 9'((`FULL_TURN / (st_ff.units_m1 + 9'h001))
                            * st_ff.order);
    else
      nxt_st.phase_deg = sel_deg(st_ff.cfg.phase_sel);
    if (st_ff.cfg.sync_mode == pol_seq_pkg::SYNC_INTERNAL && !st_ff.follower)
      nxt_st.phase_off = 10'h000;
    else
      nxt_st.phase_off = 10'(prod / 19'(`FULL_TURN));
    // switching clock: internal count, restarted by sync edge in input mode
    nxt_st.sync_prev = sync_in;
    if ((st_ff.cfg.sync_mode == pol_seq_pkg::SYNC_INPUT || st_ff.follower)
        && sync_in && !st_ff.sync_prev)
      nxt_st.sw_cnt = 10'h000;
    else if (st_ff.sw_cnt >= st_ff.per - 10'h001)
      nxt_st.sw_cnt = 10'h000;
    else
      nxt_st.sw_cnt = st_ff.sw_cnt + 10'h001;
    nxt_st.sw_pulse = (st_ff.sw_cnt == st_ff.phase_off);
    nxt_st.sync_oe = (st_ff.cfg.sync_mode == pol_seq_pkg::SYNC_OUTPUT)
                     && !st_ff.follower;
    nxt_st.sync_out = nxt_st.sync_oe && (st_ff.sw_cnt < (st_ff.per >> 1));
    // leader poll timer
    if (st_ff.leader && tick)
    begin
      if (st_ff.poll_cnt >= `POLL_MS_DEF - 8'h01)
      begin
        nxt_st.poll_cnt = 8'h00;
        nxt_st.poll = 1'b1;
      end
      else
        nxt_st.poll_cnt = st_ff.poll_cnt + 8'h01;
    end
    // sequencer
    if (tick)
      nxt_st.tcnt = st_ff.tcnt + 8'h01;
    case (st_ff.seq)
      pol_seq_pkg::SEQ_OFF:
        if (rail_enable && !fault)
        begin
          nxt_st.seq = pol_seq_pkg::SEQ_TON_DLY;
          nxt_st.tcnt = 8'h00;
        end
      pol_seq_pkg::SEQ_TON_DLY:
        if (!rail_enable)
          nxt_st.seq = pol_seq_pkg::SEQ_OFF;
        else if (st_ff.tcnt >= st_ff.cfg.ton_delay)
        begin
          nxt_st.seq = pol_seq_pkg::SEQ_RISE;
          nxt_st.tcnt = 8'h00;
        end
      pol_seq_pkg::SEQ_RISE:
        if (!rail_enable)
          nxt_st.seq = pol_seq_pkg::SEQ_OFF;
        else if (st_ff.tcnt >= st_ff.cfg.ton_rise)
          nxt_st.seq = pol_seq_pkg::SEQ_ON;
      pol_seq_pkg::SEQ_ON:
        if (!rail_enable)
        begin
          nxt_st.tcnt = 8'h00;
          nxt_st.seq = st_ff.cfg.soft_stop ? pol_seq_pkg::SEQ_TOFF_DLY
                                           : pol_seq_pkg::SEQ_OFF;
        end
      pol_seq_pkg::SEQ_TOFF_DLY:
        if (st_ff.tcnt >= st_ff.cfg.toff_delay)
        begin
          nxt_st.seq = pol_seq_pkg::SEQ_FALL;
          nxt_st.tcnt = 8'h00;
        end
      pol_seq_pkg::SEQ_FALL:
        if (st_ff.tcnt >= st_ff.cfg.toff_fall)
          nxt_st.seq = pol_seq_pkg::SEQ_OFF;
      default:
        nxt_st.seq = pol_seq_pkg::SEQ_OFF;
    endcase
    if (fault)
      nxt_st.seq = pol_seq_pkg::SEQ_OFF;
    nxt_st.ready = (nxt_st.seq == pol_seq_pkg::SEQ_ON);
    nxt_st.run = (nxt_st.seq != pol_seq_pkg::SEQ_OFF)
                 && (nxt_st.seq != pol_seq_pkg::SEQ_TON_DLY);
    nxt_st.ramp_up = (nxt_st.seq == pol_seq_pkg::SEQ_RISE);
    nxt_st.ramp_dn = (nxt_st.seq == pol_seq_pkg::SEQ_FALL);
    nxt_st.sr_on = (nxt_st.seq == pol_seq_pkg::SEQ_ON);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '0;
      st_ff.cfg.ton_delay <= `TON_DELAY_DEF;
      st_ff.cfg.ton_rise <= `TON_RISE_DEF;
      st_ff.cfg.toff_delay <= `TOFF_DELAY_DEF;
      st_ff.cfg.toff_fall <= `TOFF_FALL_DEF;
      st_ff.cfg.freq_req <= `FREQ_DEF;
      st_ff.freq_eff <= `FREQ_DEF;
      st_ff.per <= 10'(`CLK_KHZ / int'(`FREQ_DEF));
    end
    else
      st_ff <= nxt_st;
  end

  assign rail_ready_out_o = 1'b0;
  assign rail_ready_out_oe = !st_ff.ready;
  assign sync_out = st_ff.sync_out;
  assign sync_oe = st_ff.sync_oe;
  assign sw_pulse = st_ff.sw_pulse;
  assign regulating = st_ff.run;
  assign ramping_up = st_ff.ramp_up;
  assign ramping_down = st_ff.ramp_dn;
  assign rectifier_enable = st_ff.sr_on;
  assign freq_eff = st_ff.freq_eff;
  assign phase_deg = st_ff.phase_deg;
  assign ocl_limit = st_ff.ocl;
  assign relay_req = st_ff.relay;
  assign poll_req = st_ff.poll;

  sequence s_start_req;
    st_ff.seq == pol_seq_pkg::SEQ_OFF && rail_enable && !fault;
  endsequence
  sequence s_delay_entered;
    st_ff.seq == pol_seq_pkg::SEQ_TON_DLY ##0 !st_ff.ready;
  endsequence

  a_ready_only_on: assert property (@(posedge clk_sys) disable iff (reset)
    st_ff.ready |-> st_ff.seq == pol_seq_pkg::SEQ_ON && st_ff.sr_on)
    else $error("ready outside regulation");
  a_fault_drops_pg: assert property (@(posedge clk_sys) disable iff (reset)
    fault |=> !st_ff.ready && rail_ready_out_oe)
    else $error("power-good high after fault");
  a_start_delay: assert property (@(posedge clk_sys) disable iff (reset)
    s_start_req |=> s_delay_entered)
    else $error("turn-on delay not entered");
  a_low_band_freq: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_wr && cfg_in.freq_req <= 10'h1F4 |=> st_ff.freq_eff == 10'h1C2)
    else $error("low band frequency wrong");
  a_top_band_freq: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_wr && cfg_in.freq_req > 10'h334 |=> st_ff.freq_eff == 10'h384)
    else $error("top band frequency wrong");
  a_internal_no_phase: assert property (@(posedge clk_sys) disable iff (reset)
    st_ff.cfg.sync_mode == pol_seq_pkg::SYNC_INTERNAL && !st_ff.follower
    ##1 st_ff.cfg.sync_mode == pol_seq_pkg::SYNC_INTERNAL
    |-> st_ff.phase_off == 10'h000)
    else $error("phase offset without sync");
  a_stack_phase_hold: assert property (@(posedge clk_sys) disable iff (reset)
    st_ff.stack_lock && st_ff.init ##1 st_ff.init |=> $stable(st_ff.phase_deg))
    else $error("stacked phase moved");
  a_hard_stop: assert property (@(posedge clk_sys) disable iff (reset)
    st_ff.seq == pol_seq_pkg::SEQ_ON && !rail_enable && !st_ff.cfg.soft_stop
    |=> st_ff.seq == pol_seq_pkg::SEQ_OFF && !st_ff.run)
    else $error("regulation did not stop");
  a_rectifier_block: assert property (@(posedge clk_sys) disable iff (reset)
    st_ff.seq != pol_seq_pkg::SEQ_ON |-> !rectifier_enable)
    else $error("rectifier active outside regulation");
  a_leader_relay: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_wr && st_ff.leader |=> relay_req ##1 !relay_req)
    else $error("leader did not relay");
endmodule : pol_rail_seq_ctrl

// [bench/sys_sync_model.sv]
// Purpose: system side sync source feeding the unit's sync pin
// Assumes: one source per shared line; runs only while enabled
// Notes: line stands low outside bursts
`timescale 1ns/100ps
module sys_sync_model #(
  parameter int HALF = 222
) (
  // clock
  input wire logic clk_sys,
  // control
  input wire logic run,
  input wire logic dev_sync_oe,
  // sync line
  output logic sync_in
);
  int cnt = 0;
  always @(posedge clk_sys)
  begin
    // source only while the unit does not drive the line
    if (!run || dev_sync_oe)
    begin
      sync_in <= 1'b0;
      cnt <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      sync_in <= ~sync_in;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
  initial sync_in = 1'b0;
endmodule : sys_sync_model

// [bench/pol_rail_sequencing_control_test.sv]
// Purpose: self-checking bench of the rail sequencing control
// Assumes: ms tick shortened to 20 cycles
// Notes: stack straps applied on two further resets at the end
`timescale 1ns/100ps
module pol_rail_sequencing_control_test;
  localparam int MS = 20;
  logic clk_sys = 1'b0, reset = 1'b1, cfg_wr = 1'b0, follower_strap = 1'b0;
  logic rail_enable = 1'b0, fault = 1'b0, sync_run = 1'b0, sync_in;
  logic [7:0] ocl_strap_in = 8'h28;
  logic [1:0] stack_units_m1 = 2'h0, stack_order = 2'h0;
  pol_seq_pkg::cfg_s cfg_in = '0, c;
  logic rdy_o, rdy_oe, s_out, s_oe, swp, reg_on, r_up, r_dn, rect, rly, pol;
  logic [9:0] freq_eff;
  logic [8:0] phase_deg;
  logic [7:0] ocl_limit;
  int n_errors = 0, checks_done = 0, n;
  int n_rly = 0, n_pol = 0, n_swp = 0, n_sout = 0;
  logic [9:0] f_req [9] = '{10'h19B, 10'h1F3, 10'h1F9, 10'h257, 10'h262,
    10'h2C1, 10'h333, 10'h339, 10'h3E7};
  logic [9:0] f_exp [9] = '{10'h1C2, 10'h1C2, 10'h226, 10'h226, 10'h28A,
    10'h2EE, 10'h2EE, 10'h384, 10'h384};
  logic [8:0] ph_exp [6] = '{9'h000, 9'h05A, 9'h078, 9'h0B4, 9'h0F0, 9'h10E};
  always #2.5 clk_sys = ~clk_sys;
  // pulse counters for one-cycle outputs, level count for sync_out
  always @(posedge clk_sys)
  begin
    if (rly === 1'b1) n_rly++;
    if (pol === 1'b1) n_pol++;
    if (swp === 1'b1) n_swp++;
    if (s_out === 1'b1) n_sout++;
  end
  pol_rail_seq_ctrl #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .reset(reset),
    .cfg_wr(cfg_wr), .cfg_in(cfg_in), .ocl_strap_in(ocl_strap_in),
    .follower_strap(follower_strap), .stack_units_m1(stack_units_m1),
    .stack_order(stack_order), .rail_enable(rail_enable), .fault(fault),
    .sync_in(sync_in), .rail_ready_out_o(rdy_o), .rail_ready_out_oe(rdy_oe),
    .sync_out(s_out), .sync_oe(s_oe), .sw_pulse(swp), .regulating(reg_on),
    .ramping_up(r_up), .ramping_down(r_dn), .rectifier_enable(rect),
    .freq_eff(freq_eff), .phase_deg(phase_deg), .ocl_limit(ocl_limit),
    .relay_req(rly), .poll_req(pol));
  sys_sync_model u_sync (.clk_sys(clk_sys), .run(sync_run),
    .dev_sync_oe(s_oe), .sync_in(sync_in));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task do_reset;
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset
  task write_cfg;
    @(posedge clk_sys);
    cfg_in <= c;
    cfg_wr <= 1'b1;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : write_cfg
  // enable and time the start-up; power-good stays off until on
  task start_rail(input int dly);
    @(posedge clk_sys);
    rail_enable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (r_up !== 1'b1 && n < 2000)
    begin
      check(rdy_oe, 1'b1);
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(n >= (dly - 1) * MS && n <= dly * MS + 1, 1'b1);
    while (rect !== 1'b1 && n < 4000)
    begin
      check(rdy_oe, 1'b1);
      @(posedge clk_sys);
      #1;
      n++;
    end
    check({rdy_oe, reg_on, r_up}, 3'b010);
  endtask : start_rail
  initial
  begin
    fork
      begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        summarize;
      end
    join_none
    do_reset;
    check(freq_eff, 10'h1C2);
    check({rdy_oe, reg_on, s_oe}, 3'b100);
    check(ocl_limit, 8'h28);
    check(rdy_o, 1'b0);
    $display("test reset done");
    c = '0;
    c.ton_delay = 8'h0A;
    c.ton_rise = 8'h0A;
    c.toff_delay = 8'h02;
    c.toff_fall = 8'h03;
    c.sync_mode = pol_seq_pkg::SYNC_INPUT;
    for (int i = 0; i < 9; i++)
    begin
      c.freq_req = f_req[i];
      write_cfg;
      check(freq_eff, f_exp[i]);
    end
    $display("test frequency done");
    c.ocl_ovr_en = 1'b1;
    c.ocl_ovr = 8'h1E;
    sync_run <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      c.phase_sel = 3'(i);
      write_cfg;
      check(phase_deg, ph_exp[i]);
    end
    check(ocl_limit, 8'h1E);
    check(s_oe, 1'b0);
    c.sync_mode = pol_seq_pkg::SYNC_OUTPUT;
    write_cfg;
    check(s_oe, 1'b1);
    $display("test sync done");
    start_rail(10);
    @(posedge clk_sys);
    rail_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({reg_on, rect, rdy_oe}, 3'b001);
    c.soft_stop = 1'b1;
    c.ton_delay = 8'h03;
    c.ton_rise = 8'h02;
    write_cfg;
    start_rail(3);
    @(posedge clk_sys);
    rail_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({reg_on, rect, rdy_oe}, 3'b101);
    n = 0;
    while (r_dn !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(n >= MS - 2 && n <= 2 * MS, 1'b1);
    repeat (3 * MS + 4) @(posedge clk_sys);
    #1;
    check({reg_on, r_dn}, 2'b00);
    start_rail(3);
    @(posedge clk_sys);
    fault <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check({reg_on, rect, rdy_oe}, 3'b001);
    fault <= 1'b0;
    $display("test sequencing done");
    stack_units_m1 <= 2'h3;
    stack_order <= 2'h1;
    follower_strap <= 1'b1;
    do_reset;
    c.phase_sel = 3'h5;
    write_cfg;
    check(phase_deg, 9'h05A);
    check(s_oe, 1'b0);
    stack_units_m1 <= 2'h1;
    stack_order <= 2'h0;
    follower_strap <= 1'b0;
    do_reset;
    n_rly = 0;
    write_cfg;
    check(n_rly, 1);
    check(phase_deg, 9'h000);
    n_pol = 0;
    n_swp = 0;
    n_sout = 0;
    repeat (460) @(posedge clk_sys);
    #1;
    check(n_pol >= 2, 1'b1);
    check(n_swp >= 2, 1'b1);
    check(n_sout > 0, 1'b1);
    $display("test stack done");
    summarize;
  end
endmodule : pol_rail_sequencing_control_test
